// [include/rcp_pkg.sv]
// Package: constants, types and status layout for the remote command parser
`default_nettype none
package rcp_pkg;
  // ************************************************************
  // Character codes
  // ************************************************************
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_WS_LO_END = 8'h09;
  localparam logic [7:0] CH_WS_HI_BEG = 8'h0B;
  localparam logic [7:0] CH_WS_HI_END = 8'h20;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_QUERY = 8'h3F;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_LPAR = 8'h28;
  localparam logic [7:0] CH_RPAR = 8'h29;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_CASE = 8'h20;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_Z = 8'h5A;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] CH_N = 8'h4E;
  localparam logic [7:0] CH_O = 8'h4F;
  localparam logic [7:0] CH_M = 8'h4D;
  localparam logic [7:0] CH_I = 8'h49;
  localparam logic [7:0] CH_X = 8'h58;
  localparam logic [7:0] CH_ONE = 8'h31;
  // ************************************************************
  // Status summary byte layout
  // ************************************************************
  localparam int STB_QUEUE_BIT = 2;
  localparam int STB_QUES_BIT = 3;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_RQS_BIT = 6;
  localparam logic [7:0] STB_RESET = 8'h00;
  localparam logic [7:0] SRE_RESET = 8'h00;
  localparam logic [7:0] SRE_SUMMARY_MASK = 8'hBF;
  // ************************************************************
  // Parser sizes and reset values
  // ************************************************************
  localparam int CNT_W = 32;
  localparam int DIG_W = 4;
  localparam int LVL_W = 3;
  localparam logic [1:0] CHAN_DEFAULT = 2'h1;
  localparam logic [LVL_W-1:0] LVL_ROOT = 3'h0;
  // Data element kinds
  typedef enum logic [2:0] {
    RCP_D_NONE, RCP_D_CHAR, RCP_D_BOOL, RCP_D_NUM, RCP_D_EXPR,
    RCP_D_BLOCK, RCP_D_MAXV, RCP_D_MINV
  } rcp_kind_e;
  // One byte from the bus with its end-or-identify flag
  typedef struct packed {
    logic [7:0] data;
    logic eoi;
  } rcp_byte_s;
  // Decoded element handed to the instrument
  typedef struct packed {
    rcp_kind_e kind;
    logic is_query;
    logic is_common;
    logic bool_val;
    logic [1:0] chan;
    logic [LVL_W-1:0] level;
    logic unexpected;
  } rcp_elem_s;
  // Point of an arbitrary block: two payload bytes, first byte high
  typedef struct packed {
    logic [15:0] point;
    logic last;
  } rcp_point_s;
endpackage : rcp_pkg
`default_nettype wire

// [src/rcp_char_class.sv]
// Character classifier for the remote command parser
`default_nettype none
module rcp_char_class
  import rcp_pkg::*;
(
  input wire logic [7:0] ch,
  output logic is_ws,
  output logic is_alpha,
  output logic is_digit,
  output logic is_numc,
  output logic [7:0] upper
);
  // ************************************************************
  // Classification
  // ************************************************************
  // Whitespace excludes linefeed so it can terminate a message
  always_comb begin
    is_ws = (ch <= CH_WS_LO_END) ||
            (ch >= CH_WS_HI_BEG && ch <= CH_WS_HI_END);
    upper = ch & ~CH_CASE;
    is_alpha = (upper >= CH_A) && (upper <= CH_Z);
    is_digit = (ch >= CH_ZERO) && (ch <= CH_NINE);
    is_numc = is_digit || ch == CH_PLUS || ch == CH_MINUS || ch == CH_DOT;
  end
endmodule : rcp_char_class
`default_nettype wire

// [src/rcp_parser.sv]
// Program message parser with status summary byte
`default_nettype none
module rcp_parser
  import rcp_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire rcp_pkg::rcp_byte_s in_byte,
  input wire logic in_valid,
  input wire logic root_is_chan,
  input wire logic hdr_is_qenable,
  input wire logic resp_pending,
  input wire logic queue_nonempty,
  input wire logic ques_summary,
  input wire logic esb,
  input wire logic [7:0] sre,
  input wire logic poll_read,
  output rcp_pkg::rcp_elem_s elem,
  output logic elem_valid,
  output logic resp_req,
  output rcp_pkg::rcp_point_s point,
  output logic point_valid,
  output logic msg_end,
  output logic syntax_err,
  output logic [7:0] stb
);
  typedef enum {
    RCP_S_HDR, RCP_S_SEP, RCP_S_DATA, RCP_S_WORD, RCP_S_NUM, RCP_S_SUFX,
    RCP_S_EXPR, RCP_S_HASH, RCP_S_BLEN, RCP_S_BCNT, RCP_S_BDAT,
    RCP_S_BIND, RCP_S_POST
  } rcp_state_e;
  rcp_state_e st_q, st_d;
  logic is_ws, is_alpha, is_digit, is_numc;
  logic [7:0] up;
  logic [7:0] ch;
  logic [LVL_W-1:0] lvl_q, lvl_d, cur_q, cur_d;
  logic [1:0] chan_q, chan_d;
  logic query_q, query_d, common_q, common_d, first_q, first_d;
  logic nz_q, nz_d, rnd_q, rnd_d, frac_q, frac_d;
  logic [7:0] w0_q, w0_d, w1_q, w1_d;
  logic [DIG_W-1:0] blen_q, blen_d;
  logic [CNT_W-1:0] bcnt_q, bcnt_d;
  logic [7:0] hi_q, hi_d;
  logic half_q, half_d;
  rcp_elem_s elem_q, elem_d;
  logic ev_q, ev_d, rr_q, rr_d, me_q, me_d, se_q, se_d;
  rcp_point_s pt_q, pt_d;
  logic pv_q, pv_d;
  logic term;
  // ************************************************************
  // Character classification
  // ************************************************************
  assign ch = in_byte.data;
  rcp_char_class u_cls (
    .ch(ch),
    .is_ws(is_ws),
    .is_alpha(is_alpha),
    .is_digit(is_digit),
    .is_numc(is_numc),
    .upper(up)
  );
  // Linefeed, EOI or both close a message
  assign term = (ch == CH_LF) || in_byte.eoi;
  // ************************************************************
  // Parser state machine
  // ************************************************************
  // Element emission stays in one place so every path ends alike
  always_comb begin
    st_d = st_q;
    lvl_d = lvl_q;
    cur_d = cur_q;
    chan_d = chan_q;
    query_d = query_q;
    common_d = common_q;
    first_d = first_q;
    nz_d = nz_q;
    rnd_d = rnd_q;
    frac_d = frac_q;
    w0_d = w0_q;
    w1_d = w1_q;
    blen_d = blen_q;
    bcnt_d = bcnt_q;
    hi_d = hi_q;
    half_d = half_q;
    elem_d = elem_q;
    ev_d = 1'b0;
    rr_d = 1'b0;
    me_d = 1'b0;
    se_d = 1'b0;
    pt_d = pt_q;
    pv_d = 1'b0;
    elem_d.kind = RCP_D_NONE;
    elem_d.is_query = query_q;
    elem_d.is_common = common_q;
    elem_d.chan = chan_q;
    elem_d.level = common_q ? lvl_q : cur_q;
    elem_d.unexpected = 1'b0;
    if (in_valid) begin
      case (st_q)
        RCP_S_HDR: begin
          first_d = 1'b0;
          // Terminator first, so EOI on a header byte still ends the unit
          if (ch == CH_SEMI || term) begin
            ev_d = 1'b1;
            elem_d.is_query = query_q || ch == CH_QUERY;
            rr_d = query_q || ch == CH_QUERY;
            first_d = 1'b1;
            if (!common_q) begin
              lvl_d = cur_q;
            end
            cur_d = common_q ? lvl_q : cur_q;
            query_d = 1'b0;
            common_d = 1'b0;
            if (term) begin
              me_d = 1'b1;
              lvl_d = LVL_ROOT;
              cur_d = LVL_ROOT;
              chan_d = CHAN_DEFAULT;
            end
          end else if (is_ws && first_q) begin
            // Leading whitespace before a header is skipped
            first_d = 1'b1;
          end else if (ch == CH_COLON) begin
            // Only a colon opening the unit returns to the root
            if (first_q) begin
              cur_d = LVL_ROOT;
              chan_d = CHAN_DEFAULT;
            end else begin
              cur_d = cur_q + 3'h1;
            end
          end else if (ch == CH_STAR && first_q) begin
            common_d = 1'b1;
          end else if (ch == CH_QUERY) begin
            query_d = 1'b1;
          end else if (is_digit && root_is_chan && cur_q == LVL_ROOT) begin
            chan_d = ch[1:0];
          end else if (is_ws) begin
            st_d = RCP_S_SEP;
          end else if (!is_alpha && !is_digit) begin
            se_d = 1'b1;
          end
        end
        RCP_S_SEP, RCP_S_DATA: begin
          nz_d = 1'b0;
          rnd_d = 1'b0;
          frac_d = 1'b0;
          w0_d = up;
          w1_d = 8'h00;
          if (ch == CH_SEMI || term) begin
            st_d = RCP_S_POST;
          end else if (is_ws) begin
            st_d = st_q;
          end else if (ch == CH_LPAR) begin
            st_d = RCP_S_EXPR;
          end else if (ch == CH_HASH) begin
            st_d = RCP_S_HASH;
          end else if (is_numc) begin
            nz_d = is_digit && ch != CH_ZERO;
            frac_d = ch == CH_DOT;
            st_d = RCP_S_NUM;
          end else if (is_alpha) begin
            st_d = RCP_S_WORD;
          end else begin
            se_d = 1'b1;
            st_d = RCP_S_POST;
          end
        end
        RCP_S_WORD: begin
          if (is_alpha && w1_q == 8'h00) begin
            w1_d = up;
          end
          // EOI on the last letter closes the word with that letter
          if (!is_alpha || in_byte.eoi) begin
            elem_d.kind = RCP_D_CHAR;
            if (w0_q == CH_O && w1_d == CH_N) begin
              elem_d.kind = RCP_D_BOOL;
              elem_d.bool_val = 1'b1;
            end else if (w0_q == CH_O && w1_d == CH_F) begin
              elem_d.kind = RCP_D_BOOL;
              elem_d.bool_val = 1'b0;
            end else if (w0_q == CH_M && w1_d == CH_A) begin
              elem_d.kind = RCP_D_MAXV;
            end else if (w0_q == CH_M && w1_d == CH_I) begin
              elem_d.kind = RCP_D_MINV;
            end
            ev_d = 1'b1;
            st_d = RCP_S_POST;
          end
        end
        RCP_S_NUM: begin
          if (is_digit) begin
            if (!frac_q && ch != CH_ZERO) begin
              nz_d = 1'b1;
            end
            if (frac_q && !rnd_q && w1_q == 8'h00) begin
              rnd_d = ch >= 8'h35; // first fraction digit rounds
              w1_d = 8'h01;
            end
          end else if (ch == CH_DOT) begin
            frac_d = 1'b1;
          end else if (is_alpha && up == CH_E) begin
            st_d = RCP_S_SUFX; // exponent or unit; both end the value
          end else if (is_alpha) begin
            st_d = RCP_S_SUFX;
          end
          // Numeric booleans: rounded nonzero reads as 1; EOI closes too
          if (!(is_digit || is_alpha || ch == CH_DOT) || in_byte.eoi) begin
            elem_d.kind = RCP_D_NUM;
            elem_d.bool_val = nz_d || rnd_d;
            ev_d = 1'b1;
            st_d = RCP_S_POST;
          end
        end
        RCP_S_SUFX: begin
          if (!(is_alpha || is_numc) || in_byte.eoi) begin
            elem_d.kind = RCP_D_NUM;
            elem_d.bool_val = nz_q || rnd_q;
            ev_d = 1'b1;
            st_d = RCP_S_POST;
          end
        end
        RCP_S_EXPR: begin
          if (ch == CH_RPAR) begin
            elem_d.kind = RCP_D_EXPR;
            elem_d.unexpected = !hdr_is_qenable;
            se_d = !hdr_is_qenable;
            ev_d = 1'b1;
            st_d = RCP_S_POST;
          end
        end
        RCP_S_HASH: begin
          half_d = 1'b0;
          bcnt_d = '0;
          if (ch == CH_ZERO) begin
            st_d = RCP_S_BIND;
          end else if (is_digit) begin
            blen_d = ch[3:0];
            st_d = RCP_S_BCNT;
          end else begin
            se_d = 1'b1;
            st_d = RCP_S_POST;
          end
        end
        RCP_S_BCNT: begin
          // Decimal count digits, as many as the length digit says
          bcnt_d = CNT_W'(bcnt_q * 10) + CNT_W'(ch[3:0]);
          blen_d = blen_q - 4'h1;
          if (blen_q == 4'h1) begin
            st_d = RCP_S_BDAT;
          end
        end
        RCP_S_BDAT, RCP_S_BIND: begin
          half_d = !half_q;
          hi_d = ch;
          if (half_q) begin
            pt_d.point = {hi_q, ch};
            pv_d = 1'b1;
          end
          pt_d.last = 1'b0;
          if (st_q == RCP_S_BDAT) begin
            bcnt_d = bcnt_q - 32'h1;
            if (bcnt_q == 32'h1) begin
              pt_d.last = 1'b1;
              elem_d.kind = RCP_D_BLOCK;
              ev_d = 1'b1;
              st_d = RCP_S_POST;
            end
          end else if (ch == CH_LF && in_byte.eoi) begin
            // Linefeed with EOI closes the block and the message
            pv_d = 1'b0;
            pt_d.last = 1'b1;
            elem_d.kind = RCP_D_BLOCK;
            ev_d = 1'b1;
            me_d = 1'b1;
            rr_d = query_q;
            lvl_d = LVL_ROOT;
            cur_d = LVL_ROOT;
            chan_d = CHAN_DEFAULT;
            query_d = 1'b0;
            common_d = 1'b0;
            st_d = RCP_S_HDR;
          end
          // Odd count: definite ends on a high byte, indefinite after one
          if (pt_d.last && (half_q ^ (st_q == RCP_S_BDAT))) begin
            se_d = 1'b1;
          end
        end
        default: begin
          // Post element: comma, unit separator or terminator
          if (ch == CH_COMMA) begin
            st_d = RCP_S_DATA;
          end else if (ch == CH_SEMI || term) begin
            rr_d = query_q;
            if (!common_q) begin
              lvl_d = cur_q;
            end
            cur_d = common_q ? lvl_q : cur_q;
            query_d = 1'b0;
            common_d = 1'b0;
            st_d = RCP_S_HDR;
            if (term) begin
              me_d = 1'b1;
              lvl_d = LVL_ROOT;
              cur_d = LVL_ROOT;
              chan_d = CHAN_DEFAULT;
            end
          end else if (!is_ws) begin
            se_d = 1'b1;
          end
        end
      endcase
      // Bytes that close an element and also end the unit or message
      if (st_d == RCP_S_POST && (ch == CH_SEMI || term)) begin
        rr_d = query_q;
        if (!common_q) begin
          lvl_d = cur_q;
        end
        cur_d = common_q ? lvl_q : cur_q;
        query_d = 1'b0;
        common_d = 1'b0;
        st_d = RCP_S_HDR;
        if (term) begin
          me_d = 1'b1;
          lvl_d = LVL_ROOT;
          cur_d = LVL_ROOT;
          chan_d = CHAN_DEFAULT;
        end
      end else if (st_d == RCP_S_POST && ch == CH_COMMA) begin
        st_d = RCP_S_DATA;
      end
      // A new unit starts with no header byte seen
      if (st_q != RCP_S_HDR && st_d == RCP_S_HDR) begin
        first_d = 1'b1;
      end
    end
  end
  // ************************************************************
  // State registers
  // ************************************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= RCP_S_HDR;
      lvl_q <= LVL_ROOT;
      cur_q <= LVL_ROOT;
      chan_q <= CHAN_DEFAULT;
      query_q <= 1'b0;
      common_q <= 1'b0;
      first_q <= 1'b1;
      nz_q <= 1'b0;
      rnd_q <= 1'b0;
      frac_q <= 1'b0;
      w0_q <= 8'h00;
      w1_q <= 8'h00;
      blen_q <= '0;
      bcnt_q <= '0;
      hi_q <= 8'h00;
      half_q <= 1'b0;
      elem_q <= '0;
      ev_q <= 1'b0;
      rr_q <= 1'b0;
      me_q <= 1'b0;
      se_q <= 1'b0;
      pt_q <= '0;
      pv_q <= 1'b0;
    end else begin
      st_q <= st_d;
      lvl_q <= lvl_d;
      cur_q <= cur_d;
      chan_q <= chan_d;
      query_q <= query_d;
      common_q <= common_d;
      first_q <= first_d;
      nz_q <= nz_d;
      rnd_q <= rnd_d;
      frac_q <= frac_d;
      w0_q <= w0_d;
      w1_q <= w1_d;
      blen_q <= blen_d;
      bcnt_q <= bcnt_d;
      hi_q <= hi_d;
      half_q <= half_d;
      elem_q <= elem_d;
      ev_q <= ev_d;
      rr_q <= rr_d;
      me_q <= me_d;
      se_q <= se_d;
      pt_q <= pt_d;
      pv_q <= pv_d;
    end
  end
  // ************************************************************
  // Status summary byte
  // ************************************************************
  rcp_status_byte u_stb (
    .clock(clock),
    .sys_rst(sys_rst),
    .queue_nonempty(queue_nonempty),
    .ques_summary(ques_summary),
    .mav(resp_pending),
    .esb(esb),
    .sre(sre),
    .poll_read(poll_read),
    .stb(stb)
  );
  assign elem = elem_q;
  assign elem_valid = ev_q;
  assign resp_req = rr_q;
  assign point = pt_q;
  assign point_valid = pv_q;
  assign msg_end = me_q;
  assign syntax_err = se_q;
endmodule : rcp_parser
`default_nettype wire

// [src/rcp_status_byte.sv]
// Status summary byte with service request generation
`default_nettype none
module rcp_status_byte
  import rcp_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic queue_nonempty,
  input wire logic ques_summary,
  input wire logic mav,
  input wire logic esb,
  input wire logic [7:0] sre,
  input wire logic poll_read,
  output logic [7:0] stb
);
  logic [7:0] stb_q, stb_d;
  logic rqs_q, rqs_d;
  logic [7:0] summ;
  // ************************************************************
  // Summary bits and request service
  // ************************************************************
  // Request is set by any enabled summary; a poll clears it, set wins
  always_comb begin
    summ = STB_RESET;
    summ[STB_QUEUE_BIT] = queue_nonempty;
    summ[STB_QUES_BIT] = ques_summary;
    summ[STB_MAV_BIT] = mav;
    summ[STB_ESB_BIT] = esb;
    rqs_d = rqs_q;
    if (poll_read) begin
      rqs_d = 1'b0;
    end
    if (|(summ & sre & SRE_SUMMARY_MASK)) begin
      rqs_d = 1'b1;
    end
    stb_d = summ;
    stb_d[STB_RQS_BIT] = rqs_d;
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stb_q <= STB_RESET;
      rqs_q <= 1'b0;
    end else begin
      stb_q <= stb_d;
      rqs_q <= rqs_d;
    end
  end
  assign stb = stb_q;
endmodule : rcp_status_byte
`default_nettype wire

// [tb/rcp_ctrl_model.sv]
// Bus controller model that sends program messages byte by byte
`default_nettype none
module rcp_ctrl_model
  import rcp_pkg::*;
(
  input wire logic clock,
  output rcp_pkg::rcp_byte_s in_byte,
  output logic in_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    in_byte = '0;
    in_valid = 1'b0;
  end
  // One byte a cycle; idle data is inverted so stale bytes never match
  task automatic send(input string s, input logic eoi);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clock);
      in_byte.data = s[i];
      in_byte.eoi = eoi && (i == s.len() - 1);
      in_valid = 1'b1;
    end
    @(negedge clock);
    in_valid = 1'b0;
    in_byte.data = ~in_byte.data;
    in_byte.eoi = 1'b0;
  endtask : send
endmodule : rcp_ctrl_model
`default_nettype wire

// [tb/rcp_parser_assertions.sv]
// Checker for the parser ports and the status summary byte
`default_nettype none
module rcp_parser_chk
  import rcp_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire rcp_pkg::rcp_byte_s in_byte,
  input wire logic in_valid,
  input wire logic resp_pending,
  input wire logic queue_nonempty,
  input wire logic ques_summary,
  input wire logic esb,
  input wire logic [7:0] sre,
  input wire logic poll_read,
  input wire rcp_pkg::rcp_elem_s elem,
  input wire logic resp_req,
  input wire logic point_valid,
  input wire logic msg_end,
  input wire logic [7:0] stb
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Any enabled summary bit requests service
  logic rqs_cond;
  assign rqs_cond = |({esb, resp_pending, ques_summary, queue_nonempty}
                      & sre[5:2]);
  chk_unused_zero: assert property (stb[1:0] == 2'h0 && !stb[7])
    else $error("unused status bits set");
  chk_queue_bit: assert property (1'b1 |=> stb[2] == $past(queue_nonempty))
    else $error("queue bit wrong");
  chk_ques_bit: assert property (ques_summary |=> stb[3])
    else $error("questionable bit missing");
  chk_mav_bit: assert property (!resp_pending |=> !stb[4])
    else $error("message bit without response");
  chk_mav_set: assert property (resp_pending |=> stb[4])
    else $error("message bit missing");
  chk_esb_bit: assert property (1'b1 |=> stb[5] == $past(esb))
    else $error("event bit wrong");
  chk_rqs_set: assert property (rqs_cond |=> stb[6])
    else $error("service request missing");
  chk_poll_clear: assert property (poll_read && !rqs_cond |=> !stb[6])
    else $error("service request not cleared");
  chk_msg_end: assert property (msg_end |-> $past(in_valid) &&
    ($past(in_byte.data) == CH_LF || $past(in_byte.eoi)))
    else $error("message end without terminator");
  chk_point_cause: assert property (point_valid |-> $past(in_valid))
    else $error("point without byte");
  chk_resp_query: assert property (resp_req |-> elem.is_query)
    else $error("response for a command");
  cov_query: cover property (resp_req);
  cov_point: cover property (point_valid);
  cov_poll: cover property (poll_read && stb[6]);
endmodule : rcp_parser_chk
bind rcp_parser rcp_parser_chk u_chk (.clock, .sys_rst, .in_byte, .in_valid,
  .resp_pending, .queue_nonempty, .ques_summary, .esb, .sre, .poll_read,
  .elem, .resp_req, .point_valid, .msg_end, .stb);
`default_nettype wire

// [tb/remote_command_parser_status_tb.sv]
// Self-checking testbench for the parser and status byte
`default_nettype none
module remote_command_parser_status_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rcp_pkg::*;
  logic clock, sys_rst, in_valid, root_is_chan, hdr_is_qenable, poll_read;
  logic resp_pending, queue_nonempty, ques_summary, esb;
  logic elem_valid, resp_req, point_valid, msg_end, syntax_err;
  logic [7:0] sre, stb;
  rcp_byte_s in_byte;
  rcp_elem_s elem, last_elem;
  rcp_point_s point, last_pt;
  int failures = 0, comparisons = 0, n_elem, n_pt, n_err, n_end, n_resp;
  string bw[4] = '{"OUTP ON", "OUTP OFF", "OUTP 0.6", "OUTP 0.4"};
  logic bexp[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  rcp_parser u_dut (.clock, .sys_rst, .in_byte, .in_valid, .root_is_chan,
    .hdr_is_qenable, .resp_pending, .queue_nonempty, .ques_summary, .esb,
    .sre, .poll_read, .elem, .elem_valid, .resp_req, .point, .point_valid,
    .msg_end, .syntax_err, .stb);
  rcp_ctrl_model u_ctl (.clock, .in_byte, .in_valid);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Pulses are one cycle wide, so they are tallied, never polled late
  always @(negedge clock) begin
    if (elem_valid) last_elem = elem;
    if (point_valid) last_pt = point;
    n_elem += elem_valid;
    n_pt += point_valid;
    n_err += syntax_err;
    n_end += msg_end;
    n_resp += resp_req;
  end
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic msg(input string s, input logic eoi);
    {n_elem, n_pt, n_err, n_end, n_resp} = '0;
    u_ctl.send(s, eoi);
    repeat (3) @(negedge clock);
  endtask : msg
  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    print_verdict();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {sys_rst, root_is_chan, hdr_is_qenable, poll_read} = 4'h8;
    {resp_pending, queue_nonempty, ques_summary, esb} = 4'h0;
    sre = 8'h00;
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    check("stb reset", stb, 8'h00);
    msg("FREQ?\tMAX\n", 1'b0);
    check("kind", last_elem.kind, RCP_D_MAXV);
    check("query", last_elem.is_query, 1);
    check("resp", n_resp, 1);
    check("end", n_end, 1);
    foreach (bw[i]) begin
      msg(bw[i], 1'b1);
      check("bool", last_elem.bool_val, bexp[i]);
      check("eoi end", n_end, 1);
    end
    msg("VOLT 1 , 2\n", 1'b0);
    check("elements", n_elem, 2);
    msg("FREQ 1KHZ", 1'b1);
    check("suffix", last_elem.kind, RCP_D_NUM);
    check("suffix end", n_end, 1);
    msg("STAT:QUE:ENAB (1:3)\n", 1'b0);
    check("expr refused", n_err != 0, 1);
    check("unexpected", last_elem.unexpected, 1);
    hdr_is_qenable = 1'b1;
    msg("STAT:QUE:ENAB (1:3)\n", 1'b0);
    check("expr kind", last_elem.kind, RCP_D_EXPR);
    hdr_is_qenable = 1'b0;
    root_is_chan = 1'b1;
    msg("SOUR2:VOLT:AMPL 5;*ESE 255;OFFS 2\n", 1'b0);
    check("chan", last_elem.chan, 2'h2);
    check("level", last_elem.level, 3'h2);
    check("common", last_elem.is_common, 0);
    msg("SOUR:FREQ 5\n", 1'b0);
    check("default chan", last_elem.chan, 2'h1);
    root_is_chan = 1'b0;
    msg("DATA #14AB4V\n", 1'b0);
    check("points", n_pt, 2);
    check("point", last_pt.point, 16'h3456);
    msg("DATA #13ABC\n", 1'b0);
    check("odd block", n_err, 1);
    msg("DATA #0AB\n", 1'b1);
    check("indef", last_pt.point, 16'h4142);
    check("indef end", n_end, 1);
    check("indef even", n_err, 0);
    for (int b = 2; b < 6; b++) begin
      {esb, resp_pending, ques_summary, queue_nonempty} = 4'(1 << (b - 2));
      @(negedge clock);
      check("stb bit", stb, 8'h01 << b);
    end
    sre = 8'h20;
    @(negedge clock);
    check("rqs", stb, 8'h60);
    poll_read = 1'b1;
    @(negedge clock);
    check("set wins", stb, 8'h60);
    esb = 1'b0;
    @(negedge clock);
    poll_read = 1'b0;
    @(negedge clock);
    check("poll clear", stb, 8'h00);
    print_verdict();
  end
endmodule : remote_command_parser_status_tb
`default_nettype wire
